// ===== pkg/ksr_pkg.sv
`default_nettype none
package ksr_pkg;
   // Register offsets on the special function register port
   localparam logic [7:0] ADDR_INTERFACE_CONTROL = 8'h8F;
   localparam logic [7:0] ADDR_SW_RESET_TRIGGER  = 8'hE7;
   localparam logic [7:0] ADDR_UNLOCK_KEY        = 8'hF7;

   // Reset values
   localparam logic [7:0] RST_INTERFACE_CONTROL = 8'h00;
   localparam logic [7:0] RST_SW_RESET_TRIGGER  = 8'h00;
   localparam logic [7:0] RST_UNLOCK_KEY        = 8'h00;
   localparam logic [7:0] RD_IDLE_DATA          = 8'h00;

   // Field positions
   localparam int unsigned SINGLE_CLOCK_CYCLE_MODE_BIT = 7;

   // Unlock key sequence and trigger value
   localparam logic [7:0] KEY_FIRST   = 8'h55;
   localparam logic [7:0] KEY_SECOND  = 8'hAA;
   localparam logic [7:0] KEY_THIRD   = 8'h5A;
   localparam logic [7:0] SW_RESET_GO = 8'hFF;

   // Nonvolatile reset duration select codes
   localparam logic [2:0] DUR_SEL_25MS  = 3'h0;
   localparam logic [2:0] DUR_SEL_200MS = 3'h1;
   localparam logic [2:0] DUR_SEL_100MS = 3'h2;
   localparam logic [2:0] DUR_SEL_50MS  = 3'h3;
   localparam logic [2:0] DUR_SEL_16MS  = 3'h4;
   localparam logic [2:0] DUR_SEL_8MS   = 3'h5;
   localparam logic [2:0] DUR_SEL_4MS   = 3'h6;

   // Reset durations in milliseconds
   localparam int unsigned T_RST_25MS  = 25;
   localparam int unsigned T_RST_200MS = 200;
   localparam int unsigned T_RST_100MS = 100;
   localparam int unsigned T_RST_50MS  = 50;
   localparam int unsigned T_RST_16MS  = 16;
   localparam int unsigned T_RST_8MS   = 8;
   localparam int unsigned T_RST_4MS   = 4;

   // Clock period and derived cycle counts
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned NS_PER_MS     = 1000000;
   localparam int unsigned CYC_25MS  = T_RST_25MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int unsigned CYC_200MS = T_RST_200MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int unsigned CYC_100MS = T_RST_100MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int unsigned CYC_50MS  = T_RST_50MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int unsigned CYC_16MS  = T_RST_16MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int unsigned CYC_8MS   = T_RST_8MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int unsigned CYC_4MS   = T_RST_4MS * NS_PER_MS / CLK_PERIOD_NS;

   // Width of the reset hold counter
   localparam int unsigned HOLD_CNT_W = 25;

   // Unlock sequence states
   typedef enum logic [3:0] {
      KEY_IDLE     = 4'b0001,
      KEY_GOT_ONE  = 4'b0010,
      KEY_GOT_TWO  = 4'b0100,
      KEY_UNLOCKED = 4'b1000
   } ksr_key_state_t;

   // Chip reset sequencing states
   typedef enum logic [2:0] {
      RS_LOAD = 3'b001,
      RS_HOLD = 3'b010,
      RS_RUN  = 3'b100
   } ksr_rst_state_t;
endpackage : ksr_pkg
`default_nettype wire

// ===== hdl/ksr_hold_timer.sv
`default_nettype none
module ksr_hold_timer #(
   parameter int unsigned CNT_W = ksr_pkg::HOLD_CNT_W
) (
   // Clock and reset
   input  wire logic             ref_clk_in,
   input  wire logic             rst_b_in,
   // Control
   input  wire logic             load_in,
   input  wire logic [CNT_W-1:0] load_val_in,
   // Status
   output logic                  done_out
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   // Down counter; a load of N gives N cycles before done
   always_comb begin
      cnt_d = cnt_q;
      if (load_in) begin
         cnt_d = load_val_in - CNT_W'(1);
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - CNT_W'(1);
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Done never reported in the load cycle itself
   assign done_out = (cnt_q == '0) && !load_in;
endmodule : ksr_hold_timer
`default_nettype wire

// ===== hdl/ksr_reset_ctrl.sv
// Behaviour
// - The write unlock opens only after the keys 55h, AAh and 5Ah are written in that order to the key register.
// - Without a finished unlock, writes to the software reset trigger register are dropped.
// - With write permission, FFh written to the trigger starts a whole-chip reset and 00h to FEh are only stored, yet also spend the permission.
// - The software reset is ORed with every hardware reset source to form the chip reset.
// - The trigger clears to zero at the end of the reset, and trigger and key registers reset to 00h.
// - The internal reset lasts the nonvolatile-selected time of 25, 200, 100, 50, 16, 8 or 4 ms.
// - After reset the core uses two-clock machine cycles, and bit 7 of interface control selects one-clock.
`default_nettype none
module ksr_reset_ctrl #(
   parameter int unsigned CNT_W      = ksr_pkg::HOLD_CNT_W,
   parameter int unsigned CYC_25MS   = ksr_pkg::CYC_25MS,
   parameter int unsigned CYC_200MS  = ksr_pkg::CYC_200MS,
   parameter int unsigned CYC_100MS  = ksr_pkg::CYC_100MS,
   parameter int unsigned CYC_50MS   = ksr_pkg::CYC_50MS,
   parameter int unsigned CYC_16MS   = ksr_pkg::CYC_16MS,
   parameter int unsigned CYC_8MS    = ksr_pkg::CYC_8MS,
   parameter int unsigned CYC_4MS    = ksr_pkg::CYC_4MS
) (
   // Clock and power-on reset
   input  wire logic       ref_clk_in,
   input  wire logic       rst_b_in,
   // Other hardware reset sources and nonvolatile setting
   input  wire logic       hw_reset_req_in,
   input  wire logic [2:0] nv_rst_dur_sel_in,
   // Register port
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out,
   // Chip-wide results
   output logic            chip_rst_b_out,
   output logic            single_clock_cycle_mode_out,
   output logic            machine_cycle_stb_out,
   output logic            write_unlocked_out
);
   // Map a duration select code onto its hold length in cycles
   // Code 7 and any unknown code fall back to the default length
   function automatic logic [CNT_W-1:0] dur_cycles(input logic [2:0] sel);
      logic [CNT_W-1:0] c;
      c = CNT_W'(CYC_25MS);
      unique case (sel)
         ksr_pkg::DUR_SEL_200MS: c = CNT_W'(CYC_200MS);
         ksr_pkg::DUR_SEL_100MS: c = CNT_W'(CYC_100MS);
         ksr_pkg::DUR_SEL_50MS:  c = CNT_W'(CYC_50MS);
         ksr_pkg::DUR_SEL_16MS:  c = CNT_W'(CYC_16MS);
         ksr_pkg::DUR_SEL_8MS:   c = CNT_W'(CYC_8MS);
         ksr_pkg::DUR_SEL_4MS:   c = CNT_W'(CYC_4MS);
         default:                c = CNT_W'(CYC_25MS);
      endcase
      return c;
   endfunction : dur_cycles

   // Register write decode
   // Shared by every register so the strobe test is written once
   function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] target);
      return wr && (a == target);
   endfunction : wr_hit

   // Registered state and its next values
   ksr_pkg::ksr_rst_state_t rst_state_q;
   ksr_pkg::ksr_rst_state_t rst_state_d;
   ksr_pkg::ksr_key_state_t key_state_q;
   ksr_pkg::ksr_key_state_t key_state_d;
   logic [7:0]             ifctl_q;
   logic [7:0]             ifctl_d;
   logic [7:0]             trig_q;
   logic [7:0]             trig_d;
   logic [7:0]             rdata_q;
   logic [7:0]             rdata_d;
   logic                   chip_rst_b_q;
   logic                   chip_rst_b_d;
   logic                   phase_q;
   logic                   phase_d;
   logic [CNT_W-1:0]       hold_len_q;
   logic [CNT_W-1:0]       hold_len_d;
   logic                   timer_load;
   logic                   timer_done;
   logic                   running;
   logic                   key_wr;
   logic                   trig_wr;
   logic                   sw_go;

   // The chip runs exactly while the sequencer sits in RUN
   assign running = (rst_state_q == ksr_pkg::RS_RUN);
   // Core writes only count while the chip is out of reset
   assign key_wr  = running && wr_hit(reg_wr_in, reg_addr_in, ksr_pkg::ADDR_UNLOCK_KEY);
   assign trig_wr = running && (key_state_q == ksr_pkg::KEY_UNLOCKED)
                    && wr_hit(reg_wr_in, reg_addr_in, ksr_pkg::ADDR_SW_RESET_TRIGGER);
   // Other trigger values are stored and also spend the permission
   // only FFh fires
   assign sw_go   = trig_wr && (reg_wdata_in == ksr_pkg::SW_RESET_GO);

   // Unlock key sequence; permission is spent by any trigger write
   // A hardware reset request drops permission at once, so no unlock outlives running
   always_comb begin
      key_state_d = key_state_q;
      if (!running || hw_reset_req_in) begin
         key_state_d = ksr_pkg::KEY_IDLE;
      end else if (trig_wr) begin
         key_state_d = ksr_pkg::KEY_IDLE;
      end else if (key_wr) begin
         unique case (key_state_q)
            ksr_pkg::KEY_IDLE: begin
               key_state_d = (reg_wdata_in == ksr_pkg::KEY_FIRST) ? ksr_pkg::KEY_GOT_ONE : ksr_pkg::KEY_IDLE;
            end
            ksr_pkg::KEY_GOT_ONE: begin
               if (reg_wdata_in == ksr_pkg::KEY_SECOND) begin
                  key_state_d = ksr_pkg::KEY_GOT_TWO;
               end else if (reg_wdata_in == ksr_pkg::KEY_FIRST) begin
                  key_state_d = ksr_pkg::KEY_GOT_ONE;
               end else begin
                  key_state_d = ksr_pkg::KEY_IDLE;
               end
            end
            ksr_pkg::KEY_GOT_TWO: begin
               if (reg_wdata_in == ksr_pkg::KEY_THIRD) begin
                  key_state_d = ksr_pkg::KEY_UNLOCKED;
               end else if (reg_wdata_in == ksr_pkg::KEY_FIRST) begin
                  key_state_d = ksr_pkg::KEY_GOT_ONE;
               end else begin
                  key_state_d = ksr_pkg::KEY_IDLE;
               end
            end
            ksr_pkg::KEY_UNLOCKED: begin
               // A fresh key write reopens matching from the start
               key_state_d = (reg_wdata_in == ksr_pkg::KEY_FIRST) ? ksr_pkg::KEY_GOT_ONE : ksr_pkg::KEY_IDLE;
            end
            default: begin
               key_state_d = ksr_pkg::KEY_IDLE;
            end
         endcase
      end
   end

   // Trigger register; holds FFh through the reset it caused
   // The end of any reset clears it, a stored non-go value included
   always_comb begin
      trig_d = trig_q;
      if (trig_wr) begin
         trig_d = reg_wdata_in;
      end
      if ((rst_state_q == ksr_pkg::RS_HOLD) && timer_done) begin
         trig_d = ksr_pkg::RST_SW_RESET_TRIGGER;
      end
   end

   // Interface control; the whole chip reset returns it to default
   // A go write and a mode write share one strobe, so they never meet
   always_comb begin
      ifctl_d = ifctl_q;
      if (!running || sw_go) begin
         ifctl_d = ksr_pkg::RST_INTERFACE_CONTROL;
      end else if (wr_hit(reg_wr_in, reg_addr_in, ksr_pkg::ADDR_INTERFACE_CONTROL)) begin
         ifctl_d = reg_wdata_in;
      end
   end

   // Reset sequencing: capture length, hold, release
   // LOAD costs one cycle, so the chip reset stays low for the hold count plus one
   // The length is captured once, so a code change mid-hold has no effect
   always_comb begin
      rst_state_d  = rst_state_q;
      hold_len_d   = hold_len_q;
      timer_load   = 1'b0;
      chip_rst_b_d = 1'b0;
      unique case (rst_state_q)
         ksr_pkg::RS_LOAD: begin
            hold_len_d  = dur_cycles(nv_rst_dur_sel_in);
            timer_load  = 1'b1;
            rst_state_d = ksr_pkg::RS_HOLD;
         end
         ksr_pkg::RS_HOLD: begin
            if (hw_reset_req_in) begin
               rst_state_d = ksr_pkg::RS_LOAD;
            end else if (timer_done) begin
               rst_state_d  = ksr_pkg::RS_RUN;
               chip_rst_b_d = 1'b1;
            end
         end
         ksr_pkg::RS_RUN: begin
            chip_rst_b_d = 1'b1;
            if (hw_reset_req_in || sw_go) begin
               rst_state_d  = ksr_pkg::RS_LOAD;
               chip_rst_b_d = 1'b0;
            end
         end
         default: begin
            rst_state_d = ksr_pkg::RS_LOAD;
         end
      endcase
   end

   // Machine cycle strobe: every clock or every other clock
   // The mode may change in any cycle; the two-clock phase then restarts at zero
   always_comb begin
      phase_d = 1'b0;
      if (running && !ifctl_q[ksr_pkg::SINGLE_CLOCK_CYCLE_MODE_BIT]) begin
         phase_d = !phase_q;
      end
   end

   // Read data stand only in the cycle after the read strobe
   // Reads answer during chip reset too, so the held trigger can be seen
   always_comb begin
      rdata_d = ksr_pkg::RD_IDLE_DATA;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            ksr_pkg::ADDR_INTERFACE_CONTROL: rdata_d = ifctl_q;
            ksr_pkg::ADDR_SW_RESET_TRIGGER:  rdata_d = trig_q;
            // Key register is write-only
            ksr_pkg::ADDR_UNLOCK_KEY:        rdata_d = ksr_pkg::RST_UNLOCK_KEY;
            default:                         rdata_d = ksr_pkg::RD_IDLE_DATA;
         endcase
      end
   end

   // Unlock state; power-on reset starts from the first key
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         key_state_q <= ksr_pkg::KEY_IDLE;
      end else begin
         key_state_q <= key_state_d;
      end
   end

   // Trigger register
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         trig_q <= ksr_pkg::RST_SW_RESET_TRIGGER;
      end else begin
         trig_q <= trig_d;
      end
   end

   // Interface control register
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ifctl_q <= ksr_pkg::RST_INTERFACE_CONTROL;
      end else begin
         ifctl_q <= ifctl_d;
      end
   end

   // Read data register
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_q <= ksr_pkg::RD_IDLE_DATA;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Machine cycle phase
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
      end
   end

   // Reset sequencing; power-on reset starts the hold sequence
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_state_q  <= ksr_pkg::RS_LOAD;
         chip_rst_b_q <= 1'b0;
         hold_len_q   <= '0;
      end else begin
         rst_state_q  <= rst_state_d;
         chip_rst_b_q <= chip_rst_b_d;
         hold_len_q   <= hold_len_d;
      end
   end

   // Long counter kept apart so its width can track the longest time
   // Its load value is the next length, taken in the same LOAD edge
   ksr_hold_timer #(
      .CNT_W (CNT_W)
   ) ksr_hold_timer_inst (
      .ref_clk_in  (ref_clk_in),
      .rst_b_in    (rst_b_in),
      .load_in     (timer_load),
      .load_val_in (hold_len_d),
      .done_out    (timer_done)
   );

   // Outputs
   // Strobe gated by running so no machine cycle leaks out of a reset
   assign reg_rdata_out               = rdata_q;
   assign chip_rst_b_out              = chip_rst_b_q;
   assign single_clock_cycle_mode_out = ifctl_q[ksr_pkg::SINGLE_CLOCK_CYCLE_MODE_BIT];
   assign machine_cycle_stb_out       = running && (ifctl_q[ksr_pkg::SINGLE_CLOCK_CYCLE_MODE_BIT] || phase_q);
   assign write_unlocked_out          = (key_state_q == ksr_pkg::KEY_UNLOCKED);
endmodule : ksr_reset_ctrl
`default_nettype wire

// ===== sim/ksr_reset_ctrl_sva.sv
`default_nettype none
module ksr_reset_ctrl_sva (
   // Clock and reset
   input wire logic       ref_clk_in,
   input wire logic       rst_b_in,
   // Observed inputs
   input wire logic       hw_reset_req_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   // Observed outputs
   input wire logic [7:0] reg_rdata_out,
   input wire logic       chip_rst_b_out,
   input wire logic       single_clock_cycle_mode_out,
   input wire logic       machine_cycle_stb_out,
   input wire logic       write_unlocked_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);
   // Writes only count while the chip runs and no other source resets it
   wire logic live = chip_rst_b_out && !hw_reset_req_in;
   sequence s_key(logic [7:0] v);
      live && reg_wr_in && reg_addr_in == ksr_pkg::ADDR_UNLOCK_KEY && reg_wdata_in == v;
   endsequence
   sequence s_trig;
      live && reg_wr_in && reg_addr_in == ksr_pkg::ADDR_SW_RESET_TRIGGER;
   endsequence
   AST_UNLOCK_OPENS: assert property (s_key(8'h55) ##1 s_key(8'hAA) ##1 s_key(8'h5A)
      |=> write_unlocked_out)
      else $error("unlock not granted after key sequence");
   AST_UNLOCK_CAUSE: assert property ($rose(write_unlocked_out) |->
      $past(reg_wr_in && reg_addr_in == ksr_pkg::ADDR_UNLOCK_KEY && reg_wdata_in == 8'h5A))
      else $error("unlock opened without final key");
   AST_LOCKED_DROP: assert property (s_trig and !write_unlocked_out |=> chip_rst_b_out)
      else $error("locked trigger write caused reset");
   AST_GO: assert property (s_trig and write_unlocked_out && reg_wdata_in == 8'hFF |=> !chip_rst_b_out)
      else $error("trigger value did not reset");
   AST_NOGO: assert property (s_trig and write_unlocked_out && reg_wdata_in != 8'hFF |=> chip_rst_b_out)
      else $error("non trigger value caused reset");
   AST_HW_OR: assert property (chip_rst_b_out && hw_reset_req_in |=> !chip_rst_b_out)
      else $error("hardware reset request ignored");
   AST_QUIET_RST: assert property (!chip_rst_b_out |-> !machine_cycle_stb_out && !write_unlocked_out)
      else $error("activity during chip reset");
   AST_MIN_HOLD: assert property ($fell(chip_rst_b_out) |-> !chip_rst_b_out [*6])
      else $error("chip reset too short");
   AST_KEY_RD: assert property (reg_rd_in && reg_addr_in == ksr_pkg::ADDR_UNLOCK_KEY
      |=> reg_rdata_out == 8'h00)
      else $error("key register read not zero");
   AST_MODE_SET: assert property (live && reg_wr_in && reg_addr_in == ksr_pkg::ADDR_INTERFACE_CONTROL
      |=> single_clock_cycle_mode_out == $past(reg_wdata_in[7]))
      else $error("mode bit not written");
   AST_TWO_CLK: assert property (live && !single_clock_cycle_mode_out && machine_cycle_stb_out
      |=> single_clock_cycle_mode_out || !machine_cycle_stb_out)
      else $error("two clock strobe back to back");
   AST_ONE_CLK: assert property (chip_rst_b_out && single_clock_cycle_mode_out |-> machine_cycle_stb_out)
      else $error("one clock strobe missing");
endmodule : ksr_reset_ctrl_sva
bind ksr_reset_ctrl ksr_reset_ctrl_sva ksr_reset_ctrl_sva_inst (.ref_clk_in, .rst_b_in, .hw_reset_req_in,
   .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .chip_rst_b_out,
   .single_clock_cycle_mode_out, .machine_cycle_stb_out, .write_unlocked_out);
`default_nettype wire

// ===== sim/tb_ksr_reset_ctrl.sv
`default_nettype none
module tb_ksr_reset_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   // Short hold counts per duration code, last entry is the fallback code; none below 5 for the hold check
   localparam int unsigned NCYC [8] = '{20, 60, 50, 40, 16, 8, 5, 20};
   logic       ref_clk_in = 1'b0;
   logic       rst_b_in = 1'b0;
   logic       hw_reset_req_in = 1'b0;
   logic [2:0] nv_rst_dur_sel_in = 3'h0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic       reg_wr_in = 1'b0;
   logic       reg_rd_in = 1'b0;
   wire logic [7:0] reg_rdata_out;
   wire logic chip_rst_b_out;
   wire logic single_clock_cycle_mode_out;
   wire logic machine_cycle_stb_out;
   wire logic write_unlocked_out;
   int miscompares = 0;
   int n_compared = 0;
   int cyc = 0;
   ksr_reset_ctrl #(.CYC_25MS(NCYC[0]), .CYC_200MS(NCYC[1]), .CYC_100MS(NCYC[2]), .CYC_50MS(NCYC[3]),
      .CYC_16MS(NCYC[4]), .CYC_8MS(NCYC[5]), .CYC_4MS(NCYC[6])) ksr_reset_ctrl_inst (
      .ref_clk_in, .rst_b_in, .hw_reset_req_in, .nv_rst_dur_sel_in, .reg_addr_in, .reg_wdata_in,
      .reg_wr_in, .reg_rd_in, .reg_rdata_out, .chip_rst_b_out, .single_clock_cycle_mode_out,
      .machine_cycle_stb_out, .write_unlocked_out);
   // Clock
   always #5 ref_clk_in = ~ref_clk_in;
   // Cycle count, also cuts a hang short
   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      if (cyc > 6000) begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (miscompares == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp
   task automatic cmp_bit(input logic got, input logic exp, input string what);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask : cmp_bit
   // One write strobe; returns just after the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
      #1;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      #1;
      cmp(reg_rdata_out, exp, "read data");
   endtask : rd
   // three key writes, back to back
   task automatic keys();
      @(posedge ref_clk_in);
      reg_addr_in <= 8'hF7;
      reg_wdata_in <= 8'h55;
      reg_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_wdata_in <= 8'hAA;
      @(posedge ref_clk_in);
      reg_wdata_in <= 8'h5A;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
      #1;
   endtask : keys
   // Bounded wait for the chip to run again
   task automatic wait_run();
      int g;
      g = 0;
      while (chip_rst_b_out !== 1'b1 && g < 200) begin
         @(posedge ref_clk_in);
         #1;
         g++;
      end
      cmp_bit(chip_rst_b_out, 1'b1, "run wait limit");
   endtask : wait_run
   task automatic t_regs();
      rd(8'h8F, 8'h00);
      rd(8'hE7, 8'h00);
      rd(8'hF7, 8'h00);
      wr(8'h33, 8'hAA);
      rd(8'h33, 8'h00);
   endtask : t_regs
   task automatic t_mode();
      logic s0;
      wr(8'h8F, 8'h80);
      cmp_bit(single_clock_cycle_mode_out, 1'b1, "one clock mode");
      @(posedge ref_clk_in);
      #1;
      cmp_bit(machine_cycle_stb_out, 1'b1, "one clock strobe");
      rd(8'h8F, 8'h80);
      wr(8'h8F, 8'h00);
      s0 = machine_cycle_stb_out;
      @(posedge ref_clk_in);
      #1;
      cmp_bit(s0 ^ machine_cycle_stb_out, 1'b1, "two clock strobe");
   endtask : t_mode
   task automatic t_keys();
      wr(8'hE7, 8'hFF);
      cmp_bit(chip_rst_b_out, 1'b1, "locked trigger");
      rd(8'hE7, 8'h00);
      wr(8'hF7, 8'h55);
      wr(8'hF7, 8'h11);
      wr(8'hF7, 8'hAA);
      wr(8'hF7, 8'h5A);
      cmp_bit(write_unlocked_out, 1'b0, "broken sequence");
      wr(8'hF7, 8'h55);
      wr(8'hF7, 8'h55);
      wr(8'hF7, 8'hAA);
      rd(8'h8F, 8'h00);
      wr(8'hF7, 8'h5A);
      cmp_bit(write_unlocked_out, 1'b1, "restarted sequence");
      wr(8'hE7, 8'h12);
      cmp_bit(chip_rst_b_out, 1'b1, "non trigger value");
      rd(8'hE7, 8'h12);
      wr(8'hE7, 8'hFF);
      cmp_bit(chip_rst_b_out, 1'b1, "permission spent");
   endtask : t_keys
   task automatic t_swreset();
      int c0;
      for (int c = 0; c < 8; c++) begin
         @(posedge ref_clk_in);
         nv_rst_dur_sel_in <= 3'(c);
         wr(8'h8F, 8'h80);
         keys();
         cmp_bit(write_unlocked_out, 1'b1, "unlock opened");
         wr(8'hE7, 8'hFF);
         c0 = cyc;
         cmp_bit(chip_rst_b_out, 1'b0, "software reset");
         rd(8'hE7, 8'hFF);
         wr(8'hF7, 8'h55);
         wait_run();
         cmp(8'(cyc - c0), 8'(NCYC[c] + 1), "hold length");
         rd(8'hE7, 8'h00);
         rd(8'h8F, 8'h00);
         wr(8'hF7, 8'hAA);
         wr(8'hF7, 8'h5A);
         cmp_bit(write_unlocked_out, 1'b0, "key during reset");
      end
   endtask : t_swreset
   task automatic t_hw();
      wr(8'h8F, 8'h80);
      keys();
      @(posedge ref_clk_in);
      hw_reset_req_in <= 1'b1;
      @(posedge ref_clk_in);
      hw_reset_req_in <= 1'b0;
      #1;
      cmp_bit(chip_rst_b_out, 1'b0, "hardware source");
      cmp_bit(write_unlocked_out, 1'b0, "unlock after hardware reset");
      wait_run();
      cmp_bit(single_clock_cycle_mode_out, 1'b0, "mode after reset");
   endtask : t_hw
   // Main sequence
   initial begin
      repeat (8) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      #1;
      wait_run();
      cmp_bit(single_clock_cycle_mode_out, 1'b0, "default mode");
      t_regs();
      t_mode();
      t_keys();
      t_swreset();
      t_hw();
      print_verdict();
   end
endmodule : tb_ksr_reset_ctrl
`default_nettype wire
